// ===== cpu_regfile_stack_irq_entry.sv
`include "cpu_core_consts.svh"

module cpu_regfile_stack_irq_entry
    import cpu_core_pkg::*;
#(
    parameter int NUM_IRQ = 8
) (
    // Core clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Register file byte and word ports
    input  wire logic [4:0]          rd_addr_a,
    input  wire logic [4:0]          rd_addr_b,
    output logic      [7:0]          rd_data_a,
    output logic      [7:0]          rd_data_b,
    output logic      [15:0]         rd_word_a,
    input  wire logic                wr_byte_en,
    input  wire logic [4:0]          wr_byte_addr,
    input  wire logic [7:0]          wr_byte_data,
    input  wire logic                wr_word_en,
    input  wire logic [4:0]          wr_word_addr,
    input  wire logic [15:0]         wr_word_data,
    // Indirect pointer use
    input  wire logic                ptr_use,
    input  wire logic [1:0]          ptr_sel,
    input  wire ptr_mode_e           ptr_mode,
    input  wire logic [5:0]          ptr_disp_val,
    output logic      [15:0]         ptr_addr,
    // Data space access to registers and I/O
    input  wire logic [15:0]         ds_addr,
    input  wire logic                ds_rd,
    input  wire logic                ds_wr,
    input  wire logic [7:0]          ds_wdata,
    output logic      [7:0]          ds_rdata,
    output logic                     ds_hit,
    // Instruction stream events
    input  wire logic                instr_done,
    input  wire logic                multi_busy,
    input  wire logic                sleeping,
    input  wire logic                op_push,
    input  wire logic                op_pop,
    input  wire logic                op_call,
    input  wire logic                call_unwind_op,
    input  wire logic                trap_return_op,
    input  wire logic                op_mask_all,
    input  wire logic                op_unmask_all,
    input  wire logic                alu_flags_we,
    input  wire logic [6:0]          alu_flags,
    // Interrupt sources
    input  wire logic [NUM_IRQ-1:0]  irq_event,
    input  wire logic [NUM_IRQ-1:0]  irq_level,
    input  wire logic [NUM_IRQ-1:0]  irq_is_level,
    // Sequencer status
    output logic                     core_stall,
    output logic                     vector_go,
    output logic [3:0]               vector_num,
    output logic [15:0]              stack_ptr,
    output logic [7:0]               flags_word
);

    initial begin
        if (NUM_IRQ < 1 || NUM_IRQ > 8)
            $error("NUM_IRQ must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0]          regs [0:31];
    logic [7:0]          stack_ptr_low;
    logic [7:0]          stack_ptr_high;
    logic [NUM_IRQ-1:0]  irq_enable;
    logic [NUM_IRQ-1:0]  irq_flags;
    logic                inhibit_one;
    seq_state_e          state;
    logic [3:0]          count;

    // Lowest index wins: vector order equals priority
    function automatic logic [3:0] first_set(input logic [NUM_IRQ-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i])
                idx = 4'(i);
        end
        return idx;
    endfunction

    function automatic logic [4:0] ptr_low(input logic [1:0] sel);
        case (sel)
            2'h0:    return `PTR_X_LOW;
            2'h1:    return `PTR_Y_LOW;
            default: return `PTR_Z_LOW;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file reads, same cycle
    wire [4:0]  word_lo    = {rd_addr_a[4:1], 1'b0};
    assign rd_data_a = regs[rd_addr_a];
    assign rd_data_b = regs[rd_addr_b];
    assign rd_word_a = {regs[word_lo | 5'h01], regs[word_lo]};

    // Pointer effective address and update value
    wire [4:0]  p_lo       = ptr_low(ptr_sel);
    wire [15:0] p_val      = {regs[p_lo | 5'h01], regs[p_lo]};
    wire [15:0] p_dec      = p_val - 16'h0001;
    wire [15:0] p_inc      = p_val + 16'h0001;
    wire [15:0] p_dsp      = p_val + {10'h000, ptr_disp_val};
    assign ptr_addr = (ptr_mode == ptr_predec) ? p_dec :
                      (ptr_mode == ptr_disp)   ? p_dsp : p_val;
    wire        p_upd      = ptr_use && (ptr_mode == ptr_predec ||
                                         ptr_mode == ptr_postinc);
    wire [15:0] p_new      = (ptr_mode == ptr_predec) ? p_dec : p_inc;

    // Data space decode
    wire        rf_hit     = ds_addr <= `RF_LAST;
    wire        io_hit     = ds_addr >= `IO_BASE && ds_addr <= `IO_LAST;
    wire [15:0] io_off16   = ds_addr - `IO_BASE;
    wire [5:0]  io_off     = io_off16[5:0];
    wire        sel_spl    = io_hit && io_off == `IO_SP_LOW;
    wire        sel_sph    = io_hit && io_off == `IO_SP_HIGH;
    wire        sel_flg    = io_hit && io_off == `IO_FLAGS_WORD;
    wire        sel_ien    = io_hit && io_off == `IO_IRQ_ENABLE;
    wire        sel_ifl    = io_hit && io_off == `IO_IRQ_FLAGS;
    wire [7:0]  ien_rd     = 8'(irq_enable);
    wire [7:0]  ifl_rd     = 8'(irq_flags);
    assign ds_hit   = rf_hit || sel_spl || sel_sph || sel_flg ||
                      sel_ien || sel_ifl;
    assign ds_rdata = !ds_rd  ? 8'h00 :
                      rf_hit  ? regs[ds_addr[4:0]] :
                      sel_spl ? stack_ptr_low :
                      sel_sph ? stack_ptr_high :
                      sel_flg ? flags_word :
                      sel_ien ? ien_rd :
                      sel_ifl ? ifl_rd : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt selection
    wire                gie        = flags_word[`GIE_BIT];
    wire [NUM_IRQ-1:0]  req_flag   = irq_flags & ~irq_is_level;
    wire [NUM_IRQ-1:0]  req_level  = irq_level & irq_is_level;
    wire [NUM_IRQ-1:0]  pending    = (req_flag | req_level) & irq_enable;
    wire [3:0]          winner     = first_set(pending);
    wire                accept     = state == st_run && gie && |pending &&
                                     !op_mask_all && !inhibit_one &&
                                     !multi_busy;
    wire                start_ret  = state == st_run && trap_return_op;
    wire [3:0]          entry_len  = sleeping ?
                                     `ENTRY_CYCLES + `SLEEP_EXTRA :
                                     `ENTRY_CYCLES;
    wire                seq_last   = count == 4'h1;

    // Flag memory: set beats both clears
    wire [NUM_IRQ-1:0]  wr_clear   = (ds_wr && sel_ifl) ?
                                     ds_wdata[NUM_IRQ-1:0] : '0;
    wire [NUM_IRQ-1:0]  hw_clear   = accept ?
                                     (NUM_IRQ'(1) << winner) & ~irq_is_level :
                                     '0;
    wire [NUM_IRQ-1:0]  next_irq_flags = (irq_flags & ~wr_clear & ~hw_clear) |
                                         (irq_event & ~irq_is_level);

    // Stack pointer arithmetic
    wire [15:0] sp_now     = {stack_ptr_high, stack_ptr_low};
    wire [15:0] sp_less1   = sp_now - 16'h0001;
    wire [15:0] sp_less2   = sp_now - 16'h0002;
    wire [15:0] sp_plus1   = sp_now + 16'h0001;
    wire [15:0] sp_plus2   = sp_now + 16'h0002;
    wire [15:0] next_sp    = (accept || op_call) ? sp_less2 :
                             (start_ret || call_unwind_op) ? sp_plus2 :
                             op_push ? sp_less1 :
                             op_pop  ? sp_plus1 : sp_now;

    // Global enable update
    wire        ret_done   = state == st_return && seq_last;
    wire        next_gie   = accept        ? 1'b0 :
                             op_mask_all   ? 1'b0 :
                             ret_done      ? 1'b1 :
                             op_unmask_all ? 1'b1 :
                             (ds_wr && sel_flg) ? ds_wdata[`GIE_BIT] : gie;
    wire [6:0]  next_alu   = (ds_wr && sel_flg) ? ds_wdata[6:0] :
                             alu_flags_we ? alu_flags : flags_word[6:0];

    ////////////////////////////////////////////////////////////////////////
    // Register file writes, seen by reads next cycle
    always_ff @(posedge clk) begin
        if (wr_byte_en)
            regs[wr_byte_addr] <= wr_byte_data;
        if (p_upd) begin
            regs[p_lo]         <= p_new[7:0];
            regs[p_lo | 5'h01] <= p_new[15:8];
        end
        if (wr_word_en) begin
            regs[{wr_word_addr[4:1], 1'b0}] <= wr_word_data[7:0];
            regs[{wr_word_addr[4:1], 1'b1}] <= wr_word_data[15:8];
        end
        if (ds_wr && rf_hit)
            regs[ds_addr[4:0]] <= ds_wdata;
    end

    // Stack pointer; a direct write to one byte overrides stack activity for that byte only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_ptr_low  <= 8'(`SP_RESET);
            stack_ptr_high <= 8'(`SP_RESET >> 8);
        end else begin
            stack_ptr_low  <= (ds_wr && sel_spl) ? ds_wdata : next_sp[7:0];
            stack_ptr_high <= (ds_wr && sel_sph) ? ds_wdata : next_sp[15:8];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flags  <= '0;
            irq_enable <= '0;
        end else begin
            irq_flags  <= next_irq_flags;
            if (ds_wr && sel_ien)
                irq_enable <= ds_wdata[NUM_IRQ-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            flags_word <= `FLAGS_RESET;
        else
            flags_word <= {next_gie, next_alu};
    end

    // One instruction runs after trap return or unmask-all
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            inhibit_one <= 1'b0;
        else if (ret_done || op_unmask_all)
            inhibit_one <= 1'b1;
        else if (instr_done && state == st_run)
            inhibit_one <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry and return sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= st_run;
            count      <= 4'h0;
            core_stall <= 1'b0;
            vector_go  <= 1'b0;
            vector_num <= 4'h0;
        end else begin
            vector_go <= 1'b0;
            case (state)
                st_run: begin
                    if (accept) begin
                        state      <= st_entry;
                        count      <= entry_len;
                        core_stall <= 1'b1;
                        vector_num <= winner + 4'h1;
                    end else if (start_ret) begin
                        state      <= st_return;
                        count      <= `RETURN_CYCLES;
                        core_stall <= 1'b1;
                    end
                end
                st_entry: begin
                    count <= count - 4'h1;
                    if (seq_last) begin
                        state      <= st_run;
                        core_stall <= 1'b0;
                        vector_go  <= 1'b1;
                    end
                end
                st_return: begin
                    count <= count - 4'h1;
                    if (seq_last) begin
                        state      <= st_run;
                        core_stall <= 1'b0;
                    end
                end
                default: begin
                    state      <= st_run;
                    core_stall <= 1'b0;
                end
            endcase
        end
    end

    assign stack_ptr = sp_now;

endmodule // cpu_regfile_stack_irq_entry

// ===== cpu_core_consts.svh
`ifndef CPU_CORE_CONSTS_SVH
`define CPU_CORE_CONSTS_SVH
// Summary of operation
// - Thirty-two byte registers also appear at data addresses 0x00 to 0x1f.
// - Ports: 8-bit read/write, two reads, 16-bit result, 16-bit read.
// - Registers 0x1a-0x1f form three pointers, low byte at even address.
// - Pointers support displacement, post-increment and pre-decrement.
// - Stack grows down: push lowers pointer by one, pop raises it.
// - Call or interrupt entry lowers pointer by two; returns raise it.
// - Stack pointer is two readable, writable I/O bytes, zero at reset.
// - Core runs straight from the chip clock, no division.
// - Next instruction is fetched while current executes; one per clock.
// - Two-register operation reads, computes and writes back in one cycle.
// - Source accepted only with its own enable and global enable set.
// - Lower vector means higher priority; reset first, external zero next.
// - Entry clears global enable; trap return sets it; software may nest.
// - Hardware clears a source flag when vectoring to its handler.
// - Writing one to a flag clears it; writing zero leaves it.
// - Disabled flags stay pending; pending flags served by priority.
// - Level sources request while present and need no flag.
// - After trap return one main instruction runs before next interrupt.
// - Mask-all blocks interrupts at once, even one in the same cycle.
// - After unmask-all the next instruction runs before any interrupt.
// - Global enable is bit 7 of the flags word.
// - Entry takes four cycles pushing return address; sleep adds four.
// - Trap return takes four cycles, pops two bytes, sets global enable.

// Data space layout
`define RF_LAST        16'h001f
`define IO_BASE        16'h0020
`define IO_LAST        16'h005f
`define PTR_X_LOW      5'h1a
`define PTR_Y_LOW      5'h1c
`define PTR_Z_LOW      5'h1e
// I/O offsets
`define IO_SP_LOW      6'h3d
`define IO_SP_HIGH     6'h3e
`define IO_FLAGS_WORD  6'h3f
`define IO_IRQ_ENABLE  6'h3b
`define IO_IRQ_FLAGS   6'h3a
// Reset values and fields
`define SP_RESET       16'h0000
`define FLAGS_RESET    8'h00
`define GIE_BIT        7
// Timing in clock cycles
`define ENTRY_CYCLES   4'h4
`define SLEEP_EXTRA    4'h4
`define RETURN_CYCLES  4'h4
`endif

// ===== cpu_core_pkg.sv
package cpu_core_pkg;
    typedef enum logic [1:0] {
        st_run    = 2'b00,
        st_entry  = 2'b01,
        st_return = 2'b10
    } seq_state_e;

    typedef enum logic [1:0] {
        ptr_plain   = 2'b00,
        ptr_disp    = 2'b01,
        ptr_postinc = 2'b10,
        ptr_predec  = 2'b11
    } ptr_mode_e;
endpackage

// ===== irq_source_model.sv
module irq_source_model #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Service seen at the core
    input  wire logic         vector_go,
    input  wire logic [3:0]   vector_num,
    // Bench requests
    input  wire logic [N-1:0] fire,
    input  wire logic [N-1:0] hold,
    // Source lines
    output logic      [N-1:0] irq_event,
    output logic      [N-1:0] irq_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] hit;
    logic [N-1:0] served;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            hit[i] = vector_go && (vector_num == 4'(i + 1));
        end
    end
    // A handler removes its level cause until the bench raises it anew
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            served <= '0;
        end else begin
            served <= (served | hit) & hold;
        end
    end
    assign irq_level = hold & ~served;
    assign irq_event = fire;
endmodule // irq_source_model

// ===== cpu_regfile_stack_irq_entry_sva.sv
module cpu_regfile_stack_irq_entry_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Requests
    input wire logic [15:0] ds_addr,
    input wire logic        ds_wr,
    input wire logic [7:0]  ds_wdata,
    input wire logic        instr_done,
    input wire logic        sleeping,
    input wire logic        op_push,
    input wire logic        op_pop,
    input wire logic        op_call,
    input wire logic        call_unwind_op,
    input wire logic        trap_return_op,
    input wire logic        op_mask_all,
    input wire logic        op_unmask_all,
    // Status
    input wire logic        core_stall,
    input wire logic        vector_go,
    input wire logic [15:0] stack_ptr,
    input wire logic [7:0]  flags_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // No write, sequence or possible acceptance competes for the pointer
    wire quiet = !ds_wr && !core_stall && !flags_word[7];
    push_pop_a: assert property (quiet && (op_push ^ op_pop) |=>
        stack_ptr == $past(stack_ptr) + ($past(op_pop) ? 16'h1 : 16'hffff))
        else $error("push or pop moved stack pointer wrongly");
    call_unwind_a: assert property (
        quiet && (op_call ^ call_unwind_op) |=>
        stack_ptr == $past(stack_ptr) + ($past(op_call) ? 16'hfffe : 16'h2))
        else $error("call or unwind moved stack pointer wrongly");
    entry_state_a: assert property (
        $rose(core_stall) && !$past(trap_return_op) |->
        !flags_word[7] && stack_ptr == $past(stack_ptr) - 16'h2)
        else $error("entry left enable set or pointer wrong");
    entry_len_a: assert property (
        $rose(core_stall) && !$past(trap_return_op) && !sleeping |->
        core_stall[*4] ##1 (!core_stall && vector_go))
        else $error("entry did not take four cycles");
    sleep_len_a: assert property (
        $rose(core_stall) && !$past(trap_return_op) && sleeping |->
        core_stall[*8] ##1 (!core_stall && vector_go))
        else $error("entry from sleep did not take eight cycles");
    return_seq_a: assert property (
        trap_return_op && !core_stall |=>
        (core_stall && stack_ptr == $past(stack_ptr) + 16'h2) ##1
        core_stall[*3] ##1 (!core_stall && flags_word[7]))
        else $error("trap return sequence wrong");
    mask_all_a: assert property (op_mask_all && !core_stall |=>
        !core_stall && !flags_word[7])
        else $error("interrupt taken after mask all");
    unmask_hold_a: assert property (
        op_unmask_all && !core_stall && !flags_word[7] |=>
        flags_word[7] && !core_stall ##1 ($past(instr_done) || !core_stall))
        else $error("interrupt taken before next instruction");
    sp_write_a: assert property (
        ds_wr && ds_addr == 16'h005d && !core_stall && !flags_word[7] |=>
        stack_ptr[7:0] == $past(ds_wdata))
        else $error("stack pointer low byte not written");
endmodule // cpu_regfile_stack_irq_entry_chk

bind cpu_regfile_stack_irq_entry cpu_regfile_stack_irq_entry_chk chk (
    .clk(clk), .reset_n(reset_n), .ds_addr(ds_addr), .ds_wr(ds_wr),
    .ds_wdata(ds_wdata), .instr_done(instr_done), .sleeping(sleeping),
    .op_push(op_push), .op_pop(op_pop), .op_call(op_call),
    .call_unwind_op(call_unwind_op), .trap_return_op(trap_return_op),
    .op_mask_all(op_mask_all), .op_unmask_all(op_unmask_all),
    .core_stall(core_stall), .vector_go(vector_go),
    .stack_ptr(stack_ptr), .flags_word(flags_word));

// ===== cpu_regfile_stack_irq_entry_tb_top.sv
module cpu_regfile_stack_irq_entry_tb_top;
    import cpu_core_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("Error %s expected %0h seen %0h", n, e, g); \
        end \
    end
    logic        clk = 0, reset_n = 0, ds_rd = 0, ds_wr = 0, ptr_use = 0;
    logic        wr_byte_en = 0, wr_word_en = 0, instr_done = 0, sleeping = 0;
    logic        op_push = 0, op_pop = 0, op_call = 0, call_unwind_op = 0;
    logic        trap_return_op = 0, op_mask_all = 0, op_unmask_all = 0;
    logic        alu_flags_we = 0, ds_hit, core_stall, vector_go;
    logic        multi_busy = 0;
    logic [4:0]  rd_addr_a = 0, rd_addr_b = 0;
    logic [4:0]  wr_byte_addr = 0, wr_word_addr = 0;
    logic [7:0]  wr_byte_data = 0, ds_wdata = 0;
    logic [7:0]  rd_data_a, rd_data_b, ds_rdata, flags_word;
    logic [15:0] wr_word_data = 0, ds_addr = 0, rd_word_a, ptr_addr, stack_ptr;
    logic [6:0]  alu_flags = 0;
    logic [5:0]  ptr_disp_val = 0;
    logic [1:0]  ptr_sel = 0;
    ptr_mode_e   ptr_mode = ptr_plain;
    logic [3:0]  fire = 0, hold = 0, irq_event, irq_level, vector_num;
    int          failures = 0, samples_checked = 0, cycles = 0;
    always #50 clk = ~clk;
    cpu_regfile_stack_irq_entry #(.NUM_IRQ(4)) uut (
        .clk(clk), .reset_n(reset_n), .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
        .rd_word_a(rd_word_a), .wr_byte_en(wr_byte_en),
        .wr_byte_addr(wr_byte_addr), .wr_byte_data(wr_byte_data),
        .wr_word_en(wr_word_en), .wr_word_addr(wr_word_addr),
        .wr_word_data(wr_word_data), .ptr_use(ptr_use), .ptr_sel(ptr_sel),
        .ptr_mode(ptr_mode), .ptr_disp_val(ptr_disp_val), .ptr_addr(ptr_addr),
        .ds_addr(ds_addr), .ds_rd(ds_rd), .ds_wr(ds_wr), .ds_wdata(ds_wdata),
        .ds_rdata(ds_rdata), .ds_hit(ds_hit), .instr_done(instr_done),
        .multi_busy(multi_busy), .sleeping(sleeping), .op_push(op_push),
        .op_pop(op_pop), .op_call(op_call), .call_unwind_op(call_unwind_op),
        .trap_return_op(trap_return_op), .op_mask_all(op_mask_all),
        .op_unmask_all(op_unmask_all), .alu_flags_we(alu_flags_we),
        .alu_flags(alu_flags), .irq_event(irq_event), .irq_level(irq_level),
        .irq_is_level(4'b1000), .core_stall(core_stall),
        .vector_go(vector_go), .vector_num(vector_num),
        .stack_ptr(stack_ptr), .flags_word(flags_word));
    irq_source_model #(.N(4)) src (
        .clk(clk), .reset_n(reset_n), .vector_go(vector_go),
        .vector_num(vector_num), .fire(fire), .hold(hold),
        .irq_event(irq_event), .irq_level(irq_level));
    ////////////////////////////////////////////////////////////////////////
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        ds_addr = a;
        ds_wdata = d;
        ds_wr = 1'b1;
        @(negedge clk);
        ds_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        ds_addr = a;
        ds_rd = 1'b1;
        #10 d = ds_rdata;
        @(negedge clk);
        ds_rd = 1'b0;
    endtask
    task automatic wait_vec(output int n);
        n = 0;
        for (int i = 0; i < 20 && vector_go !== 1'b1; i++) begin
            @(negedge clk);
            if (core_stall === 1'b1) n++;
        end
    endtask
    task automatic ret();
        pulse(trap_return_op);
        repeat (4) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] d;
        `CHK("stack_ptr", 16'h0000, stack_ptr)
        `CHK("flags_word", 8'h00, flags_word)
        rd(16'h005e, d);
        `CHK("sp_high", 8'h00, d)
        wr(16'h005d, 8'h5f);
        wr(16'h005e, 8'h01);
        rd(16'h005d, d);
        `CHK("sp_low", 8'h5f, d)
        `CHK("ds_hit", 1'b1, ds_hit)
        `CHK("stack_ptr", 16'h015f, stack_ptr)
        rd(16'h0060, d);
        `CHK("unmapped", 8'h00, d)
        `CHK("ds_hit", 1'b0, ds_hit)
        alu_flags = 7'h55;
        pulse(alu_flags_we);
        `CHK("flags_word", 8'h55, flags_word)
    endtask
    task automatic t_file();
        logic [7:0] d;
        wr_byte_addr = 5'h05;
        wr_byte_data = 8'ha5;
        pulse(wr_byte_en);
        wr_word_addr = 5'h1a;
        wr_word_data = 16'h1234;
        pulse(wr_word_en);
        rd_addr_a = 5'h05;
        rd_addr_b = 5'h1b;
        #10 `CHK("rd_data_a", 8'ha5, rd_data_a)
        `CHK("rd_data_b", 8'h12, rd_data_b)
        @(negedge clk);
        rd_addr_a = 5'h1a;
        #10 `CHK("rd_word_a", 16'h1234, rd_word_a)
        rd(16'h0005, d);
        `CHK("ds_reg", 8'ha5, d)
        wr(16'h001f, 8'h3c);
        rd_addr_b = 5'h1f;
        #10 `CHK("rd_data_b", 8'h3c, rd_data_b)
    endtask
    task automatic t_ptr();
        wr_word_addr = 5'h1e;
        wr_word_data = 16'h0100;
        pulse(wr_word_en);
        ptr_sel = 2'd2;
        ptr_use = 1'b1;
        ptr_mode = ptr_postinc;
        #10 `CHK("postinc", 16'h0100, ptr_addr)
        @(negedge clk);
        ptr_mode = ptr_predec;
        #10 `CHK("predec", 16'h0100, ptr_addr)
        @(negedge clk);
        ptr_mode = ptr_disp;
        ptr_disp_val = 6'h3f;
        #10 `CHK("disp", 16'h013f, ptr_addr)
        @(negedge clk);
        ptr_use = 1'b0;
        rd_addr_a = 5'h1e;
        #10 `CHK("ptr_z", 16'h0100, rd_word_a)
    endtask
    task automatic t_stack();
        pulse(op_push);
        `CHK("push", 16'h015e, stack_ptr)
        pulse(op_pop);
        `CHK("pop", 16'h015f, stack_ptr)
        pulse(op_call);
        `CHK("call", 16'h015d, stack_ptr)
        pulse(call_unwind_op);
        `CHK("unwind", 16'h015f, stack_ptr)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_irq();
        logic [7:0] d;
        int         n;
        wr(16'h005b, 8'h0f);
        fire = 4'b0110;
        @(negedge clk);
        fire = 4'b0000;
        repeat (3) @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        rd(16'h005a, d);
        `CHK("pending", 4'b0110, d[3:0])
        pulse(op_unmask_all);
        @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        pulse(instr_done);
        wait_vec(n);
        `CHK("entry_len", 4, n)
        `CHK("vector", 4'h2, vector_num)
        `CHK("gie", 1'b0, flags_word[7])
        `CHK("alu_keep", 7'h55, flags_word[6:0])
        `CHK("entry_sp", 16'h015d, stack_ptr)
        rd(16'h005a, d);
        `CHK("flag_clr", 4'b0100, d[3:0])
        ret();
        `CHK("gie", 1'b1, flags_word[7])
        `CHK("ret_sp", 16'h015f, stack_ptr)
        repeat (2) @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        multi_busy = 1'b1;
        pulse(instr_done);
        repeat (2) @(negedge clk);
        `CHK("busy_stall", 1'b0, core_stall)
        multi_busy = 1'b0;
        wait_vec(n);
        `CHK("vector", 4'h3, vector_num)
        ret();
    endtask
    task automatic t_mask();
        logic [7:0] d;
        pulse(instr_done);
        fire = 4'b0001;
        @(negedge clk);
        fire = 4'b0000;
        pulse(op_mask_all);
        repeat (3) @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        `CHK("gie", 1'b0, flags_word[7])
        wr(16'h005b, 8'h0e);
        wr(16'h005f, 8'h80);
        repeat (3) @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        wr(16'h005a, 8'h00);
        rd(16'h005a, d);
        `CHK("w1c_zero", 4'b0001, d[3:0])
        wr(16'h005a, 8'h01);
        rd(16'h005a, d);
        `CHK("w1c_one", 4'b0000, d[3:0])
    endtask
    task automatic t_level();
        int n;
        wr(16'h005f, 8'h00);
        hold = 4'b1000;
        repeat (2) @(negedge clk);
        hold = 4'b0000;
        pulse(op_unmask_all);
        pulse(instr_done);
        repeat (3) @(negedge clk);
        `CHK("stall", 1'b0, core_stall)
        sleeping = 1'b1;
        hold = 4'b1000;
        wait_vec(n);
        `CHK("sleep_len", 8, n)
        `CHK("vector", 4'h4, vector_num)
        sleeping = 1'b0;
        hold = 4'b0000;
        ret();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_regs();
        t_file();
        t_ptr();
        t_stack();
        t_irq();
        t_mask();
        t_level();
        summarize();
    end
endmodule // cpu_regfile_stack_irq_entry_tb_top
